// File: rtl/vdst_regs.vh
// constants for the video dram shifter transfer block
// assumes inclusion by rtl/vdst_top.v and rtl/vdst_shifter.v
`ifndef VDST_REGS_VH
`define VDST_REGS_VH
`define VDST_ROW_W 8
`define VDST_COL_W 8
`define VDST_COLS 256
`define VDST_NIB_W 4
`define VDST_VIDEO_CLOCK_MAX_MHZ 25
`define VDST_CLK_MHZ 100
// least video clock period in reference cycles, rounded up
`define VDST_VIDEO_CLOCK_MIN_CYC ((`VDST_CLK_MHZ + `VDST_VIDEO_CLOCK_MAX_MHZ - 1) / `VDST_VIDEO_CLOCK_MAX_MHZ)
`endif

// File: rtl/vdst_shifter.v
// serial shifter: 256x4 flip-flop sram with an 8-bit wrapping counter
// assumes all controls arrive synchronous to ref_clk_i, one-cycle pulses except the wr_mode_i and clear_i levels
`timescale 1ns/1ns
`include "vdst_regs.vh"
module vdst_shifter (
	// clock and reset
	input wire ref_clk_i,
	input wire sys_rst_i,
	// control pulses
	input wire load_cnt_i,
	input wire [`VDST_COL_W-1:0] load_val_i,
	input wire video_clock_rise_i,
	input wire wr_mode_i,
	input wire [`VDST_NIB_W-1:0] ser_in_i,
	input wire par_load_i,
	input wire [`VDST_NIB_W*`VDST_COLS-1:0] par_data_i,
	input wire clear_i,
	input wire [`VDST_NIB_W-1:0] clear_mask_i,
	// contents
	output wire [`VDST_NIB_W*`VDST_COLS-1:0] par_data_o,
	output wire [`VDST_NIB_W-1:0] nib_o,
	output wire [`VDST_COL_W-1:0] cnt_o
);
	reg [`VDST_COL_W-1:0] cnt_q;
	reg [`VDST_NIB_W-1:0] mem_q [0:`VDST_COLS-1];
	genvar gi;

	// counter: load wins over increment, wraps naturally at all ones
	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_q <= 8'h00;
		end else if (load_cnt_i) begin
			cnt_q <= load_val_i;
		end else if (video_clock_rise_i) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	// one nibble per column; clear, parallel load, or serial write
	generate
		for (gi = 0; gi < `VDST_COLS; gi = gi + 1) begin : g_col
			always @(posedge ref_clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					mem_q[gi] <= 4'h0;
				end else if (clear_i) begin
					mem_q[gi] <= clear_mask_i;
				end else if (par_load_i) begin
					mem_q[gi] <= par_data_i[gi*`VDST_NIB_W +: `VDST_NIB_W];
				end else if (wr_mode_i && video_clock_rise_i && cnt_q == gi) begin
					mem_q[gi] <= ser_in_i;
				end
			end
			assign par_data_o[gi*`VDST_NIB_W +: `VDST_NIB_W] = mem_q[gi];
		end
	endgenerate

	assign nib_o = mem_q[cnt_q];
	assign cnt_o = cnt_q;
endmodule

// File: rtl/vdst_top.v
// transfer control, dram row store and serial port of a dual-port video dram
// assumes all strobes and the video clock are asynchronous pins sampled at 100 MHz
`timescale 1ns/1ns
`include "vdst_regs.vh"
module vdst_top (
	// clock and reset
	input wire ref_clk_i,
	input wire sys_rst_i,
	// dram strobes, active low pins
	input wire row_strobe_n_i,
	input wire col_strobe_n_i,
	input wire write_enable_n_i,
	input wire transfer_gate_n_i,
	input wire shifter_gate_reset_n_i,
	input wire [`VDST_ROW_W-1:0] multiplexed_address_i,
	// dram data pins
	input wire [`VDST_NIB_W-1:0] dram_data_i,
	output wire [`VDST_NIB_W-1:0] dram_data_o,
	output wire dram_data_oe_o,
	// serial port
	input wire video_clock_i,
	input wire [`VDST_NIB_W-1:0] serial_data_i,
	output wire [`VDST_NIB_W-1:0] serial_data_o,
	output wire serial_data_oe_o
);
	localparam ST_IDLE = 2'd0;
	localparam ST_NORM = 2'd1;
	localparam ST_XFER = 2'd2;

	reg [1:0] st_q, st_d;
	reg [5:0] s1_q, s2_q, s3_q;
	reg [`VDST_ROW_W-1:0] a1_q, a2_q;
	reg [`VDST_NIB_W-1:0] d1_q, d2_q, sd1_q, sd2_q;
	reg [`VDST_ROW_W-1:0] row_q, col_q;
	reg d2s_q, wr_mode_q, rst_pend_q;
	reg [`VDST_NIB_W-1:0] mask_q, dout_q, sout_q;
	reg [`VDST_NIB_W*`VDST_COLS-1:0] dram_q [0:`VDST_COLS-1];
	wire ras_fall, ras_rise, cas_fall, video_clock_rise;
	wire [`VDST_NIB_W*`VDST_COLS-1:0] shf_par;
	wire [`VDST_NIB_W-1:0] shf_nib;
	wire xfer_cas, do_clear, do_pload;
	// bits: write enable, video clock, gate/reset, transfer gate, column, row
	wire [5:0] s_now;

	// picks one nibble of a row at a column
	function [`VDST_NIB_W-1:0] nib_at;
		input [`VDST_NIB_W*`VDST_COLS-1:0] rowv;
		input [`VDST_COL_W-1:0] c;
		begin
			nib_at = rowv[c*`VDST_NIB_W +: `VDST_NIB_W];
		end
	endfunction

	// two-flop sync of every pin; stage three only feeds edge detection
	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s1_q <= 6'h3f;
			s2_q <= 6'h3f;
			s3_q <= 6'h3f;
			a1_q <= 8'h00;
			a2_q <= 8'h00;
			d1_q <= 4'h0;
			d2_q <= 4'h0;
			sd1_q <= 4'h0;
			sd2_q <= 4'h0;
		end else begin
			s1_q <= {write_enable_n_i, video_clock_i, shifter_gate_reset_n_i, transfer_gate_n_i,
				col_strobe_n_i, row_strobe_n_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
			a1_q <= multiplexed_address_i;
			a2_q <= a1_q;
			d1_q <= dram_data_i;
			d2_q <= d1_q;
			sd1_q <= serial_data_i;
			sd2_q <= sd1_q;
		end
	end

	assign s_now = s2_q;
	assign ras_fall = s3_q[0] & ~s_now[0];
	assign ras_rise = ~s3_q[0] & s_now[0];
	assign cas_fall = s3_q[1] & ~s_now[1];
	// video clock edges count only outside transfers (counter enable)
	assign video_clock_rise = ~s3_q[4] & s_now[4] & (st_q != ST_XFER);

	// cycle kind decided at row strobe fall
	always @* begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: begin
				if (ras_fall) begin
					st_d = s_now[2] ? ST_NORM : ST_XFER;
				end
			end
			ST_NORM, ST_XFER: begin
				if (ras_rise) begin
					st_d = ST_IDLE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_q <= ST_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	assign xfer_cas = (st_q == ST_XFER) & cas_fall;

	// transfer control latches: row, direction, mask, mode, reset request
	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			row_q <= 8'h00;
			col_q <= 8'h00;
			d2s_q <= 1'b1;
			wr_mode_q <= 1'b0;
			rst_pend_q <= 1'b0;
			mask_q <= 4'h0;
		end else begin
			if (st_q == ST_IDLE && ras_fall) begin
				row_q <= a2_q;
				col_q <= a2_q;
				if (!s_now[2]) begin
					d2s_q <= s_now[5]; // high write enable: dram to shifter
					if (s_now[5]) begin
						mask_q <= d2_q;
					end
				end
			end
			if (st_q == ST_NORM && cas_fall) begin
				col_q <= a2_q;
			end
			if (xfer_cas) begin
				wr_mode_q <= ~s_now[5]; // low write enable: write mode
				// gate/reset high on a dram-to-shifter transfer requests clear; otherwise none
				rst_pend_q <= d2s_q & s_now[3];
			end else if (ras_rise) begin
				rst_pend_q <= 1'b0; // reset ends with the cycle
			end
		end
	end

	// reset overrides the row copy; clear holds from column fall to row rise
	assign do_clear = (xfer_cas & d2s_q & s_now[3]) | rst_pend_q;
	assign do_pload = xfer_cas & d2s_q & ~s_now[3];

	// dram array: row write-back from shifter, normal early write
	genvar gr;
	generate
		for (gr = 0; gr < `VDST_COLS; gr = gr + 1) begin : g_row
			always @(posedge ref_clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					dram_q[gr] <= {(`VDST_NIB_W*`VDST_COLS){1'b0}};
				end else if (xfer_cas && !d2s_q && row_q == gr) begin
					dram_q[gr] <= shf_par; // shifter to dram
				end else if (st_q == ST_NORM && cas_fall && !s_now[5] && row_q == gr) begin
					dram_q[gr][a2_q*`VDST_NIB_W +: `VDST_NIB_W] <= d2_q;
				end
			end
		end
	endgenerate

	// serial engine; write only on video edges so cascaded data falls through
	vdst_shifter u_shf (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.load_cnt_i(xfer_cas),
		.load_val_i(a2_q),
		.video_clock_rise_i(video_clock_rise),
		.wr_mode_i(wr_mode_q),
		.ser_in_i(sd2_q),
		.par_load_i(do_pload),
		.par_data_i(dram_q[row_q]),
		.clear_i(do_clear),
		.clear_mask_i(mask_q),
		.par_data_o(shf_par),
		.nib_o(shf_nib),
		.cnt_o()
	);

	// registered output data; shifter nibble follows counter
	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dout_q <= 4'h0;
			sout_q <= 4'h0;
		end else begin
			dout_q <= nib_at(dram_q[row_q], col_q);
			sout_q <= shf_nib;
		end
	end

	assign dram_data_o = dout_q;
	// off during transfers and idle; in normal cycles low transfer gate with high write enable is output enable
	assign dram_data_oe_o = (st_q == ST_NORM) & ~s_now[2] & s_now[5];
	assign serial_data_o = sout_q;
	// read mode only, gate/reset low enables the serial drivers
	assign serial_data_oe_o = ~wr_mode_q & ~s_now[3];
endmodule

// File: tb/vdst_monitor.sv
// checker: pin level relations of the transfer block
// assumes binding onto vdst_top, pins sampled by the 100 MHz clock
`timescale 1ns/1ns
`include "vdst_regs.vh"
module vdst_monitor (
	input wire ref_clk_i,
	input wire sys_rst_i,
	input wire row_strobe_n_i,
	input wire col_strobe_n_i,
	input wire transfer_gate_n_i,
	input wire shifter_gate_reset_n_i,
	input wire video_clock_i,
	input wire dram_data_oe_o,
	input wire serial_data_oe_o,
	input wire [`VDST_NIB_W-1:0] serial_data_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	// cycle starts, told apart by the gate level at row fall
	sequence norm_start;
		$fell(row_strobe_n_i) && transfer_gate_n_i;
	endsequence
	sequence xfer_start;
		$fell(row_strobe_n_i) && !transfer_gate_n_i;
	endsequence
	chk_dram_off_xfer: assert property (xfer_start |-> (!dram_data_oe_o)[*8])
		else $error("dram outputs on in transfer");
	chk_dram_on_read: assert property (norm_start ##6
		(!row_strobe_n_i && !transfer_gate_n_i)[*5] |-> dram_data_oe_o)
		else $error("dram outputs off in read");
	chk_dram_off_gate: assert property (transfer_gate_n_i[*5] |-> !dram_data_oe_o)
		else $error("dram outputs on with gate high");
	chk_dram_off_idle: assert property (row_strobe_n_i[*6] |-> !dram_data_oe_o)
		else $error("dram outputs on while idle");
	chk_ser_off_gate: assert property (shifter_gate_reset_n_i[*5] |-> !serial_data_oe_o)
		else $error("serial outputs on with gate high");
	chk_ser_hold: assert property ((row_strobe_n_i && $stable(video_clock_i))[*8]
		|=> $stable(serial_data_o))
		else $error("serial data moved without video edge");
	chk_xfer_no_load: assert property ((!row_strobe_n_i && col_strobe_n_i
		&& !transfer_gate_n_i)[*8] |=> $stable(serial_data_o))
		else $error("serial data moved before column fall");
	chk_norm_hold: assert property (norm_start ##1 (!row_strobe_n_i
		&& $stable(video_clock_i))[*8] |=> $stable(serial_data_o))
		else $error("plain cycle touched shifter");
endmodule
bind vdst_top vdst_monitor u_mon (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
	.row_strobe_n_i(row_strobe_n_i), .col_strobe_n_i(col_strobe_n_i),
	.transfer_gate_n_i(transfer_gate_n_i), .shifter_gate_reset_n_i(shifter_gate_reset_n_i),
	.video_clock_i(video_clock_i), .dram_data_oe_o(dram_data_oe_o),
	.serial_data_oe_o(serial_data_oe_o), .serial_data_o(serial_data_o));

// File: tb/vdst_gfx_ctrl.sv
// partner: graphics controller driving strobes, address and pins
// assumes the bench calls its tasks one at a time
`timescale 1ns/1ns
module vdst_gfx_ctrl (
	input wire clk_i,
	output logic row_n_o = 1'h1,
	output logic col_n_o = 1'h1,
	output logic we_n_o = 1'h1,
	output logic gate_n_o = 1'h1,
	output logic gr_n_o = 1'h0,
	output logic vid_o = 1'h0,
	output logic [7:0] addr_o = 8'h0,
	output logic [3:0] dq_o = 4'h0,
	output logic [3:0] sd_o = 4'h0
);
	task step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// close any cycle; released data shows a fresh level, not the old one
	task done;
		{row_n_o, col_n_o, gate_n_o, we_n_o, gr_n_o} = 5'h1e;
		dq_o = ~dq_o;
		step(8);
	endtask
	// only this device's row strobe moves, between lines
	// low w_row copies shifter to row, repeatable to clear
	task xfer(input logic w_row, w_col, gr, input logic [7:0] row, col, input logic [3:0] m);
		gate_n_o = 1'h0;
		we_n_o = w_row;
		addr_o = row;
		dq_o = m;
		step(4);
		row_n_o = 1'h0;
		step(3);
		dq_o = ~m;
		step(3);
		addr_o = col;
		we_n_o = w_col;
		gr_n_o = gr; // also usable as bank select
		step(6);
		col_n_o = 1'h0;
		step(8);
		done;
	endtask
	// plain cycle left open for sampling; read drops gate as output enable
	task norm(input logic we_n, input logic [7:0] row, col, input logic [3:0] d);
		addr_o = row;
		step(4);
		row_n_o = 1'h0;
		step(4);
		addr_o = col;
		we_n_o = we_n;
		gate_n_o = !we_n;
		dq_o = d;
		step(4);
		col_n_o = 1'h0;
		step(8);
	endtask
	// 125 ns period, under the 25 MHz ceiling
	task pulse(input logic [3:0] sd);
		sd_o = sd;
		#62 vid_o = 1'h1;
		#63 vid_o = 1'h0;
		sd_o = ~sd;
		step(8);
	endtask
endmodule

// File: tb/video_dram_shifter_transfer_tb.sv
// bench: drives the transfer block through the controller model
// assumes the design header sits on the include path
`timescale 1ns/1ns
module video_dram_shifter_transfer_tb;
	logic clk = 1'h0;
	logic rst = 1'h1;
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;
	wire r_n, c_n, w_n, g_n, gr_n, vid, d_oe, s_oe;
	wire [7:0] addr;
	wire [3:0] m_dq, m_sd, d_o, s_o;
	// shared pins resolved from the device's output enables
	wire [3:0] dq = d_oe ? d_o : m_dq;
	wire [3:0] sd = s_oe ? s_o : m_sd;
	always #5 clk = ~clk;
	vdst_gfx_ctrl ctl (.clk_i(clk), .row_n_o(r_n), .col_n_o(c_n), .we_n_o(w_n),
		.gate_n_o(g_n), .gr_n_o(gr_n), .vid_o(vid), .addr_o(addr), .dq_o(m_dq), .sd_o(m_sd));
	vdst_top uut (.ref_clk_i(clk), .sys_rst_i(rst), .row_strobe_n_i(r_n),
		.col_strobe_n_i(c_n), .write_enable_n_i(w_n), .transfer_gate_n_i(g_n),
		.shifter_gate_reset_n_i(gr_n), .multiplexed_address_i(addr), .dram_data_i(dq),
		.dram_data_o(d_o), .dram_data_oe_o(d_oe), .video_clock_i(vid),
		.serial_data_i(sd), .serial_data_o(s_o), .serial_data_oe_o(s_oe));
	task chk(input string name, input logic [3:0] exp, got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task complete_run;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// hang guard, far above the few hundred cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			complete_run;
		end
	end
	task test_read;
		ctl.norm(1'h0, 8'h21, 8'hff, 4'ha);
		ctl.done;
		ctl.norm(1'h0, 8'h21, 8'h00, 4'h5);
		ctl.done;
		ctl.norm(1'h1, 8'h21, 8'hff, 4'h0);
		chk("dram read", 4'ha, d_o);
		ctl.done;
		ctl.xfer(1'h1, 1'h1, 1'h0, 8'h21, 8'hff, 4'h0);
		chk("first nibble", 4'ha, s_o);
		chk("serial oe", 4'h1, {3'h0, s_oe});
		ctl.pulse(4'h0);
		chk("wrapped nibble", 4'h5, s_o);
		$display("test read done");
	endtask
	task test_clear;
		ctl.xfer(1'h1, 1'h1, 1'h1, 8'h21, 8'h00, 4'hc);
		chk("cleared nibble", 4'hc, s_o);
		ctl.pulse(4'h0);
		chk("cleared next", 4'hc, s_o);
		$display("test clear done");
	endtask
	task test_write;
		ctl.xfer(1'h1, 1'h0, 1'h0, 8'h21, 8'h10, 4'h0);
		ctl.pulse(4'h3);
		ctl.pulse(4'h6);
		ctl.xfer(1'h0, 1'h1, 1'h0, 8'h42, 8'h10, 4'h0);
		chk("written nibble", 4'h3, s_o);
		ctl.xfer(1'h1, 1'h1, 1'h0, 8'h42, 8'h11, 4'h0);
		chk("row copy back", 4'h6, s_o);
		$display("test write done");
	endtask
	initial begin
		repeat (3) @(posedge clk);
		#1 rst = 1'h0;
		ctl.step(4);
		test_read;
		test_clear;
		test_write;
		complete_run;
	end
endmodule
